/* File: hdl/fcd_defines.vh */
// Constants shared by the floating-point front-end decode and exception block
`ifndef FCD_DEFINES_VH
`define FCD_DEFINES_VH

// ****************************************
// Decoded operation codes
// ****************************************
`define FCD_OP_OTHER 4'h0
`define FCD_OP_LOAD 4'h1
`define FCD_OP_EXTRACT 4'h2
`define FCD_OP_LDPI 4'h3
`define FCD_OP_EXAM 4'h4
`define FCD_OP_COM 4'h5
`define FCD_OP_COMP 4'h6
`define FCD_OP_XCH 4'h7
`define FCD_OP_STP 4'h8
`define FCD_OP_FREE 4'h9
`define FCD_OP_NOP 4'ha

// ****************************************
// Load source formats
// ****************************************
`define FCD_FMT_SGL 2'h0
`define FCD_FMT_DBL 2'h1
`define FCD_FMT_EXT 2'h2
`define FCD_FMT_REG 2'h3

// ****************************************
// Rounding control encodings
// ****************************************
`define FCD_RC_NEAR 2'h0
`define FCD_RC_DOWN 2'h1
`define FCD_RC_UP 2'h2
`define FCD_RC_ZERO 2'h3

// ****************************************
// Opcode groups (low three bits pick the stack register), single opcodes and load encodings
// ****************************************
`define FCD_G_LD 16'hd9c0
`define FCD_G_XCH 16'hd9c8
`define FCD_G_STP_NOUF 16'hd9d8
`define FCD_G_COM 16'hd8d0
`define FCD_G_COMP 16'hd8d8
`define FCD_G_STP 16'hddd8
`define FCD_G_FREE 16'hddc0
`define FCD_G_XCH_A1 16'hd0c8
`define FCD_G_XCH_A2 16'hdfc8
`define FCD_G_COM_A 16'hdcd0
`define FCD_G_COMP_A1 16'hdcd8
`define FCD_G_COMP_A2 16'hded0
`define FCD_G_STP_A1 16'hdfd0
`define FCD_G_STP_A2 16'hdfd8
`define FCD_G_FREEP 16'hdfc0
`define FCD_OPC_INT_EN 16'hdbe0
`define FCD_OPC_INT_DIS 16'hdbe1
`define FCD_OPC_SET_PROT 16'hdbe4
`define FCD_OPC_LDPI 16'hd9eb
`define FCD_OPC_EXTRACT 16'hd9f4
`define FCD_OPC_EXAM 16'hd9e5
`define FCD_B_LD_SGL 8'hd9
`define FCD_B_LD_DBL 8'hdd
`define FCD_B_LD_EXT 8'hdb
`define FCD_R_LD 3'h0
`define FCD_R_LD_EXT 3'h5

// ****************************************
// Exponent constants and the pi constant
// ****************************************
`define FCD_EXT_BIAS 15'h3fff
`define FCD_EXT_EMAX 15'h7fff
`define FCD_SGL_NORM_ADJ 15'h3f80
`define FCD_SGL_DEN_EXP 15'h3f81
`define FCD_DBL_NORM_ADJ 15'h3c00
`define FCD_DBL_DEN_EXP 15'h3c01
`define FCD_PI_EXP 15'h4000
`define FCD_PI_MANT 64'hc90fdaa22168c234
`define FCD_PI_GS 2'h3

// ****************************************
// Split store states
// ****************************************
`define FCD_ST_IDLE 2'h0
`define FCD_ST_LO 2'h1
`define FCD_ST_HI 2'h2

`endif

/* File: hdl/fcd_load_cvt.v */
// Load converter from single, double or extended source into extended format
`timescale 1ns/1ps
`include "fcd_defines.vh"

module fcd_load_cvt (
  input wire [1:0] fmt_i,
  input wire [79:0] raw_i,
  output reg [79:0] ext_o,
  output reg snan_o,
  output reg denorm_o
);

  reg [63:0] m;
  reg [14:0] e;
  integer i;

  always @* begin
    m = 64'h0;
    e = 15'h0;
    ext_o = raw_i;
    snan_o = 1'b0;
    denorm_o = 1'b0;
    if (fmt_i == `FCD_FMT_SGL) begin
      m = {1'b0, raw_i[22:0], 40'h0};
      if (raw_i[30:23] == 8'hff) begin
        snan_o = !raw_i[22] && (raw_i[21:0] != 22'h0);
        ext_o = {raw_i[31], `FCD_EXT_EMAX, 1'b1, raw_i[22] | snan_o, raw_i[21:0], 40'h0};
      end else if (raw_i[30:23] != 8'h0) begin
        ext_o = {raw_i[31], {7'h0, raw_i[30:23]} + `FCD_SGL_NORM_ADJ, 1'b1, raw_i[22:0], 40'h0};
      end else if (raw_i[22:0] == 23'h0) begin
        ext_o = {raw_i[31], 79'h0};
      end else begin
        // Denormal source is normalized, never left as an unnormal
        denorm_o = 1'b1;
        e = `FCD_SGL_DEN_EXP;
        for (i = 0; i < 23; i = i + 1) begin
          if (!m[63]) begin
            m = m << 1;
            e = e - 15'h1;
          end
        end
        ext_o = {raw_i[31], e, m};
      end
    end else if (fmt_i == `FCD_FMT_DBL) begin
      m = {1'b0, raw_i[51:0], 11'h0};
      if (raw_i[62:52] == 11'h7ff) begin
        snan_o = !raw_i[51] && (raw_i[50:0] != 51'h0);
        ext_o = {raw_i[63], `FCD_EXT_EMAX, 1'b1, raw_i[51] | snan_o, raw_i[50:0], 11'h0};
      end else if (raw_i[62:52] != 11'h0) begin
        ext_o = {raw_i[63], {4'h0, raw_i[62:52]} + `FCD_DBL_NORM_ADJ, 1'b1, raw_i[51:0], 11'h0};
      end else if (raw_i[51:0] == 52'h0) begin
        ext_o = {raw_i[63], 79'h0};
      end else begin
        denorm_o = 1'b1;
        e = `FCD_DBL_DEN_EXP;
        for (i = 0; i < 52; i = i + 1) begin
          if (!m[63]) begin
            m = m << 1;
            e = e - 15'h1;
          end
        end
        ext_o = {raw_i[63], e, m};
      end
    end
    // Extended and register sources pass unchanged: not arithmetic, so no denormal flag
  end

endmodule

/* File: hdl/fcd_op_decode.v */
// Opcode decoder mapping defined and aliased register-form opcodes to operations
`timescale 1ns/1ps
`include "fcd_defines.vh"

module fcd_op_decode (
  input wire [15:0] opcode_i,
  input wire mem_i,
  output reg [3:0] op_o,
  output reg [2:0] idx_o,
  output reg pop_o,
  output reg no_uflow_o,
  output reg free_o,
  output reg [1:0] fmt_o,
  output reg fault_o
);

  function in_grp;
    input [15:0] opc;
    input [15:0] base;
    begin
      in_grp = (opc[15:3] == base[15:3]);
    end
  endfunction

  always @* begin
    op_o = `FCD_OP_OTHER;
    idx_o = opcode_i[2:0];
    pop_o = 1'b0;
    no_uflow_o = 1'b0;
    free_o = 1'b0;
    fmt_o = `FCD_FMT_REG;
    // Only the escape byte range is floating point; the one alias outside it is exempt below
    fault_o = (opcode_i[15:11] != 5'b11011) && !in_grp(opcode_i, `FCD_G_XCH_A1);
    if (mem_i) begin
      if (opcode_i[15:8] == `FCD_B_LD_SGL && opcode_i[5:3] == `FCD_R_LD) begin
        op_o = `FCD_OP_LOAD;
        fmt_o = `FCD_FMT_SGL;
      end else if (opcode_i[15:8] == `FCD_B_LD_DBL && opcode_i[5:3] == `FCD_R_LD) begin
        op_o = `FCD_OP_LOAD;
        fmt_o = `FCD_FMT_DBL;
      end else if (opcode_i[15:8] == `FCD_B_LD_EXT && opcode_i[5:3] == `FCD_R_LD_EXT) begin
        op_o = `FCD_OP_LOAD;
        fmt_o = `FCD_FMT_EXT;
      end
    end else if (opcode_i == `FCD_OPC_INT_EN || opcode_i == `FCD_OPC_INT_DIS ||
                 opcode_i == `FCD_OPC_SET_PROT) begin
      op_o = `FCD_OP_NOP;
    end else if (opcode_i == `FCD_OPC_LDPI) begin
      op_o = `FCD_OP_LDPI;
    end else if (opcode_i == `FCD_OPC_EXTRACT) begin
      op_o = `FCD_OP_EXTRACT;
    end else if (opcode_i == `FCD_OPC_EXAM) begin
      op_o = `FCD_OP_EXAM;
    end else if (in_grp(opcode_i, `FCD_G_LD)) begin
      op_o = `FCD_OP_LOAD;
    end else if (in_grp(opcode_i, `FCD_G_COM) || in_grp(opcode_i, `FCD_G_COM_A)) begin
      op_o = `FCD_OP_COM;
    end else if (in_grp(opcode_i, `FCD_G_COMP) || in_grp(opcode_i, `FCD_G_COMP_A1) ||
                 in_grp(opcode_i, `FCD_G_COMP_A2)) begin
      op_o = `FCD_OP_COMP;
      pop_o = 1'b1;
    end else if (in_grp(opcode_i, `FCD_G_XCH) || in_grp(opcode_i, `FCD_G_XCH_A1) ||
                 in_grp(opcode_i, `FCD_G_XCH_A2)) begin
      op_o = `FCD_OP_XCH;
    end else if (in_grp(opcode_i, `FCD_G_STP) || in_grp(opcode_i, `FCD_G_STP_A1) ||
                 in_grp(opcode_i, `FCD_G_STP_A2)) begin
      op_o = `FCD_OP_STP;
      pop_o = 1'b1;
    end else if (in_grp(opcode_i, `FCD_G_STP_NOUF)) begin
      op_o = `FCD_OP_STP;
      pop_o = 1'b1;
      no_uflow_o = 1'b1;
    end else if (in_grp(opcode_i, `FCD_G_FREE)) begin
      op_o = `FCD_OP_FREE;
      free_o = 1'b1;
    end else if (in_grp(opcode_i, `FCD_G_FREEP)) begin
      op_o = `FCD_OP_FREE;
      free_o = 1'b1;
      pop_o = 1'b1;
    end
  end

endmodule

/* File: hdl/fcd_top.v */
// Floating-point front end: decode, issue synchronization, load/extract/constant/examine results
`timescale 1ns/1ps
`include "fcd_defines.vh"

module fcd_top (
  input wire clk_i,
  input wire reset_i,
  input wire issue_valid_i,
  input wire [15:0] issue_opcode_i,
  input wire issue_mem_i,
  input wire [31:0] issue_mem_addr_i,
  input wire serialize_i,
  output wire issue_ready_o,
  input wire [1:0] rc_i,
  input wire tag_empty_i,
  input wire [79:0] op_data_i,
  input wire [79:0] load_data_i,
  input wire dp_done_i,
  input wire mem_idle_i,
  input wire st_req_i,
  input wire st_split_i,
  input wire st_fault_hi_i,
  output wire st_ready_o,
  output wire st_lo_we_o,
  output wire st_hi_we_o,
  output wire st_abort_o,
  output reg dec_valid_o,
  output reg [3:0] op_o,
  output reg [2:0] stk_idx_o,
  output reg pop_o,
  output reg no_underflow_o,
  output reg free_o,
  output reg [1:0] rc_o,
  output reg invalid_opcode_fault_o,
  output reg res_valid_o,
  output reg [79:0] res_o,
  output reg [79:0] res_one_o,
  output reg res_one_we_o,
  output reg exc_invalid_o,
  output reg exc_denormal_o,
  output reg exc_zdiv_o,
  output reg [3:0] cc_o,
  output reg [31:0] last_mem_ptr_o
);

  // ****************************************
  // Helper functions
  // ****************************************
  function [79:0] int_to_ext;
    input [15:0] v;
    reg [63:0] mm;
    reg [14:0] ex;
    reg [15:0] mag;
    integer k;
    begin
      mag = v[15] ? (~v + 16'h1) : v;
      mm = {mag, 48'h0};
      ex = `FCD_EXT_BIAS + 15'hf;
      for (k = 0; k < 16; k = k + 1) begin
        if (!mm[63]) begin
          mm = mm << 1;
          ex = ex - 15'h1;
        end
      end
      int_to_ext = (mag == 16'h0) ? 80'h0 : {v[15], ex, mm};
    end
  endfunction

  function round_inc;
    input [1:0] rc;
    input sgn;
    input lsb;
    input [1:0] gs;
    begin
      case (rc)
        `FCD_RC_NEAR: round_inc = gs[1] & (gs[0] | lsb);
        `FCD_RC_DOWN: round_inc = sgn & (gs != 2'h0);
        `FCD_RC_UP: round_inc = !sgn & (gs != 2'h0);
        default: round_inc = 1'b0;
      endcase
    end
  endfunction

  // ****************************************
  // Decode and load conversion
  // ****************************************
  wire [3:0] dec_op;
  wire [2:0] dec_idx;
  wire dec_pop;
  wire dec_nouf;
  wire dec_free;
  wire [1:0] dec_fmt;
  wire dec_fault;
  wire [79:0] cvt_ext;
  wire cvt_snan;
  wire cvt_den;

  fcd_op_decode u_decode (
    .opcode_i(issue_opcode_i),
    .mem_i(issue_mem_i),
    .op_o(dec_op),
    .idx_o(dec_idx),
    .pop_o(dec_pop),
    .no_uflow_o(dec_nouf),
    .free_o(dec_free),
    .fmt_o(dec_fmt),
    .fault_o(dec_fault)
  );

  fcd_load_cvt u_cvt (
    .fmt_i(dec_fmt),
    .raw_i(dec_fmt == `FCD_FMT_REG ? op_data_i : load_data_i),
    .ext_o(cvt_ext),
    .snan_o(cvt_snan),
    .denorm_o(cvt_den)
  );

  // ****************************************
  // Issue synchronization
  // ****************************************
  reg busy_q;
  reg [1:0] st_state_q;
  wire accept;
  wire ext_op;
  wire all_idle;

  assign all_idle = !busy_q && mem_idle_i && (st_state_q == `FCD_ST_IDLE);
  // A new op is held off until the previous datapath op has retired
  assign issue_ready_o = !busy_q && (!serialize_i || all_idle);
  assign accept = issue_valid_i && issue_ready_o;
  assign ext_op = !dec_fault && (dec_op == `FCD_OP_COM || dec_op == `FCD_OP_COMP ||
                  dec_op == `FCD_OP_XCH || dec_op == `FCD_OP_STP ||
                  dec_op == `FCD_OP_FREE || dec_op == `FCD_OP_OTHER);

  always @(posedge clk_i) begin
    if (reset_i) begin
      busy_q <= 1'b0;
    end else if (accept) begin
      busy_q <= ext_op;
    end else if (dp_done_i) begin
      busy_q <= 1'b0;
    end
  end

  // ****************************************
  // Local result computation
  // ****************************************
  wire op_sgn = op_data_i[79];
  wire [14:0] op_exp = op_data_i[78:64];
  wire [63:0] op_man = op_data_i[63:0];
  wire op_zero = (op_exp == 15'h0) && (op_man == 64'h0);
  wire op_inf = (op_exp == `FCD_EXT_EMAX) && (op_man[62:0] == 63'h0);
  wire op_nan = (op_exp == `FCD_EXT_EMAX) && !op_inf;
  wire [15:0] op_unb = {1'b0, op_exp} - {1'b0, `FCD_EXT_BIAS};
  wire pi_inc = round_inc(rc_i, 1'b0, |(`FCD_PI_MANT & 64'h1), `FCD_PI_GS);
  reg [79:0] r_d;
  reg [79:0] r1_d;
  reg r1_we_d;
  reg inv_d;
  reg den_d;
  reg zd_d;

  always @* begin
    r_d = 80'h0;
    r1_d = 80'h0;
    r1_we_d = 1'b0;
    inv_d = 1'b0;
    den_d = 1'b0;
    zd_d = 1'b0;
    case (dec_op)
      `FCD_OP_LOAD: begin
        r_d = cvt_ext;
        inv_d = cvt_snan;
        den_d = cvt_den && dec_fmt != `FCD_FMT_EXT && dec_fmt != `FCD_FMT_REG;
      end
      `FCD_OP_LDPI: begin
        r_d = {1'b0, `FCD_PI_EXP, `FCD_PI_MANT + {63'h0, pi_inc}};
      end
      `FCD_OP_EXTRACT: begin
        r1_we_d = 1'b1;
        if (op_zero) begin
          zd_d = 1'b1;
          r_d = {op_sgn, 79'h0};
          r1_d = {1'b1, `FCD_EXT_EMAX, 1'b1, 63'h0};
        end else if (op_inf) begin
          r_d = op_data_i;
          r1_d = {1'b0, `FCD_EXT_EMAX, 1'b1, 63'h0};
        end else if (op_nan) begin
          inv_d = !op_man[62];
          r_d = {op_data_i[79:63], 1'b1, op_man[61:0]};
          r1_d = r_d;
        end else begin
          // Extended denormals report denormal and use the minimum exponent, unnormalized
          den_d = (op_exp == 15'h0);
          r_d = {op_sgn, `FCD_EXT_BIAS, op_man};
          r1_d = int_to_ext(op_exp == 15'h0 ? 16'hc002 : op_unb);
        end
      end
      default: begin
        r_d = 80'h0;
      end
    endcase
  end

  // Examine classification as {C3,C2,C1,C0}
  reg [3:0] cc_d;
  always @* begin
    if (tag_empty_i) begin
      cc_d = 4'b1001;
    end else if (op_nan) begin
      cc_d = {2'b00, op_sgn, 1'b1};
    end else if (op_inf) begin
      cc_d = {2'b01, op_sgn, 1'b1};
    end else if (op_zero) begin
      cc_d = {2'b10, op_sgn, 1'b0};
    end else if (op_exp == 15'h0) begin
      cc_d = {2'b11, op_sgn, 1'b0};
    end else if (op_man[63]) begin
      cc_d = {2'b01, op_sgn, 1'b0};
    end else begin
      cc_d = {2'b00, op_sgn, 1'b0};
    end
  end

  // ****************************************
  // Registered outputs
  // ****************************************
  always @(posedge clk_i) begin
    if (reset_i) begin
      dec_valid_o <= 1'b0;
      op_o <= `FCD_OP_OTHER;
      stk_idx_o <= 3'h0;
      pop_o <= 1'b0;
      no_underflow_o <= 1'b0;
      free_o <= 1'b0;
      rc_o <= `FCD_RC_NEAR;
      invalid_opcode_fault_o <= 1'b0;
      res_valid_o <= 1'b0;
      res_o <= 80'h0;
      res_one_o <= 80'h0;
      res_one_we_o <= 1'b0;
      exc_invalid_o <= 1'b0;
      exc_denormal_o <= 1'b0;
      exc_zdiv_o <= 1'b0;
      cc_o <= 4'h0;
      last_mem_ptr_o <= 32'h0;
    end else begin
      dec_valid_o <= accept && !dec_fault;
      invalid_opcode_fault_o <= accept && dec_fault;
      res_valid_o <= accept && !dec_fault && !ext_op && dec_op != `FCD_OP_NOP;
      res_one_we_o <= accept && !dec_fault && r1_we_d;
      exc_invalid_o <= accept && !dec_fault && inv_d;
      exc_denormal_o <= accept && !dec_fault && den_d;
      exc_zdiv_o <= accept && !dec_fault && zd_d;
      if (accept && !dec_fault) begin
        op_o <= dec_op;
        stk_idx_o <= dec_idx;
        pop_o <= dec_pop;
        no_underflow_o <= dec_nouf;
        free_o <= dec_free;
        // Mode travels with the op so the datapath's accuracy and monotonic
        // behaviour is not disturbed by a later mode change
        rc_o <= rc_i;
        res_o <= r_d;
        res_one_o <= r1_d;
        if (dec_op == `FCD_OP_EXAM) begin
          cc_o <= cc_d;
        end
        // Pointer only moves on memory ops, so it goes stale otherwise
        if (issue_mem_i && dec_op != `FCD_OP_NOP) begin
          last_mem_ptr_o <= issue_mem_addr_i;
        end
      end
    end
  end

  // ****************************************
  // Split operand store
  // ****************************************
  reg [1:0] st_state_d;
  reg st_split_q;

  assign st_ready_o = (st_state_q == `FCD_ST_IDLE);
  assign st_lo_we_o = (st_state_q == `FCD_ST_LO);
  // No rollback of the low half: a late fault leaves it in memory
  assign st_hi_we_o = (st_state_q == `FCD_ST_HI) && !st_fault_hi_i;
  assign st_abort_o = (st_state_q == `FCD_ST_HI) && st_fault_hi_i;

  always @* begin
    case (st_state_q)
      `FCD_ST_IDLE: st_state_d = st_req_i ? `FCD_ST_LO : `FCD_ST_IDLE;
      `FCD_ST_LO: st_state_d = st_split_q ? `FCD_ST_HI : `FCD_ST_IDLE;
      `FCD_ST_HI: st_state_d = `FCD_ST_IDLE;
      default: st_state_d = `FCD_ST_IDLE;
    endcase
  end

  always @(posedge clk_i) begin
    if (reset_i) begin
      st_state_q <= `FCD_ST_IDLE;
      st_split_q <= 1'b0;
    end else begin
      st_state_q <= st_state_d;
      if (st_state_q == `FCD_ST_IDLE && st_req_i) begin
        st_split_q <= st_split_i;
      end
    end
  end

endmodule

/* File: tb/fcd_pipe_model.sv */
// Partner model: datapath completion and memory write drain
`timescale 1ns/1ps
`include "fcd_defines.vh"

module fcd_pipe_model (
  input wire clk_i,
  input wire reset_i,
  input wire dec_valid_i,
  input wire [3:0] op_i,
  input wire st_lo_we_i,
  input wire [3:0] lat_i,
  output reg dp_done_o,
  output wire mem_idle_o
);
  reg [3:0] dp_q;
  reg [3:0] mem_q;
  wire local_op;

  assign local_op = op_i inside {`FCD_OP_LOAD, `FCD_OP_EXTRACT, `FCD_OP_LDPI, `FCD_OP_EXAM, `FCD_OP_NOP};
  // Writes stay pending a while so serializing ops must really wait
  assign mem_idle_o = (mem_q == 4'h0);

  always @(posedge clk_i) begin
    if (reset_i) begin
      dp_done_o <= 1'b0;
      dp_q <= 4'h0;
      mem_q <= 4'h0;
    end else begin
      if (dec_valid_i && !local_op) begin
        dp_q <= lat_i;
      end else if (dp_q != 4'h0) begin
        dp_q <= dp_q - 4'h1;
      end
      dp_done_o <= (dp_q == 4'h1);
      if (st_lo_we_i) begin
        mem_q <= 4'h6;
      end else if (mem_q != 4'h0) begin
        mem_q <= mem_q - 4'h1;
      end
    end
  end
endmodule

/* File: tb/fcd_top_props.sv */
// Concurrent checks on the front-end ports
`timescale 1ns/1ps
`include "fcd_defines.vh"

module fcd_top_props (
  input wire clk_i,
  input wire reset_i,
  input wire issue_valid_i,
  input wire issue_ready_o,
  input wire [15:0] issue_opcode_i,
  input wire serialize_i,
  input wire [79:0] op_data_i,
  input wire tag_empty_i,
  input wire dp_done_i,
  input wire mem_idle_i,
  input wire st_req_i,
  input wire st_split_i,
  input wire st_fault_hi_i,
  input wire st_ready_o,
  input wire st_lo_we_o,
  input wire st_hi_we_o,
  input wire st_abort_o,
  input wire dec_valid_o,
  input wire [3:0] op_o,
  input wire [2:0] stk_idx_o,
  input wire invalid_opcode_fault_o,
  input wire [79:0] res_one_o,
  input wire res_one_we_o,
  input wire exc_invalid_o,
  input wire exc_zdiv_o,
  input wire [3:0] cc_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  wire acc = issue_valid_i && issue_ready_o;
  wire xtr = acc && issue_opcode_i == `FCD_OPC_EXTRACT;
  wire hi8 = issue_opcode_i[15:11] == 5'h1b;

  sequence split_take;
    st_req_i && st_ready_o && st_split_i;
  endsequence
  sequence lo_then_fault;
    st_lo_we_o ##1 st_fault_hi_i;
  endsequence
  sequence ext_issued;
    dec_valid_o && !(op_o inside {`FCD_OP_LOAD, `FCD_OP_EXTRACT, `FCD_OP_LDPI, `FCD_OP_EXAM, `FCD_OP_NOP});
  endsequence

  extract_zero_a: assert property (xtr && op_data_i[78:0] == 79'h0 |=> exc_zdiv_o && res_one_we_o &&
    res_one_o == 80'hffff8000000000000000) else $error("extract of zero wrong");
  extract_inf_a: assert property (xtr && op_data_i == 80'h7fff8000000000000000 |=>
    !exc_zdiv_o && !exc_invalid_o) else $error("extract of infinity raised");
  exam_empty_a: assert property (acc && issue_opcode_i == `FCD_OPC_EXAM && tag_empty_i |=>
    cc_o != 4'hb && cc_o != 4'hf) else $error("examine empty code forbidden");
  legacy_nop_a: assert property (acc && issue_opcode_i inside {`FCD_OPC_INT_EN, `FCD_OPC_INT_DIS,
    `FCD_OPC_SET_PROT} |=> op_o == `FCD_OP_NOP && !exc_invalid_o && $stable(cc_o)) else $error("legacy op not nop");
  alias_idx_a: assert property (acc && hi8 |=> !invalid_opcode_fault_o &&
    stk_idx_o == $past(issue_opcode_i[2:0])) else $error("alias index or fault wrong");
  ext_wait_a: assert property (ext_issued |-> !issue_ready_o) else $error("ready during outstanding op");
  ready_back_a: assert property (dp_done_i |=> issue_ready_o || serialize_i) else $error("ready not back");
  serial_a: assert property (acc && serialize_i |-> mem_idle_i && st_ready_o) else $error("serialize early");
  split_abort_a: assert property (split_take ##1 lo_then_fault |-> st_abort_o && !st_hi_we_o)
    else $error("split fault not aborted");
  split_ok_a: assert property (split_take |=> st_lo_we_o ##1 (st_fault_hi_i || st_hi_we_o))
    else $error("split store order wrong");
endmodule

bind fcd_top fcd_top_props i_fcd_top_props (.clk_i(clk_i), .reset_i(reset_i), .issue_valid_i(issue_valid_i),
  .issue_ready_o(issue_ready_o), .issue_opcode_i(issue_opcode_i), .serialize_i(serialize_i), .op_data_i(op_data_i),
  .tag_empty_i(tag_empty_i), .dp_done_i(dp_done_i), .mem_idle_i(mem_idle_i), .st_req_i(st_req_i),
  .st_split_i(st_split_i), .st_fault_hi_i(st_fault_hi_i), .st_ready_o(st_ready_o), .st_lo_we_o(st_lo_we_o),
  .st_hi_we_o(st_hi_we_o), .st_abort_o(st_abort_o), .dec_valid_o(dec_valid_o), .op_o(op_o), .stk_idx_o(stk_idx_o),
  .invalid_opcode_fault_o(invalid_opcode_fault_o), .res_one_o(res_one_o), .res_one_we_o(res_one_we_o),
  .exc_invalid_o(exc_invalid_o), .exc_zdiv_o(exc_zdiv_o), .cc_o(cc_o));

/* File: tb/tb_fpu_compat_decode_exceptions.sv */
// Self-checking bench for the floating-point front end
`timescale 1ns/1ps
`include "fcd_defines.vh"

module tb_fpu_compat_decode_exceptions;
  logic clk_i = 0, reset_i = 1, issue_valid_i = 0, issue_mem_i = 0, serialize_i = 0, tag_empty_i = 0;
  logic st_req_i = 0, st_split_i = 0, st_fault_hi_i = 0, dp_done_i, mem_idle_i;
  logic [15:0] issue_opcode_i = 16'h0;
  logic [31:0] issue_mem_addr_i = 32'h0;
  logic [1:0] rc_i = 2'h0;
  logic [79:0] op_data_i = 80'h0, load_data_i = 80'h0, res_o, res_one_o;
  logic [3:0] lat = 4'h1, op_o, cc_o;
  logic [2:0] stk_idx_o;
  logic [1:0] rc_o;
  logic [31:0] last_mem_ptr_o;
  logic issue_ready_o, st_ready_o, st_lo_we_o, st_hi_we_o, st_abort_o, dec_valid_o, pop_o, no_underflow_o;
  logic free_o, invalid_opcode_fault_o, res_valid_o, res_one_we_o, exc_invalid_o, exc_denormal_o, exc_zdiv_o;
  logic [95:0] exp_q[$];
  logic [95:0] e;
  logic [19:0] t;
  logic [31:0] last_addr = 32'h0;
  integer num_errors = 0, samples_checked = 0, cyc = 0, seed = 32'hb3fb, i;
  logic [19:0] tbl[16] = '{20'hdcd05, 20'hdcd86, 20'hded06, 20'hd0c87, 20'hdfc87, 20'hdfd08, 20'hdfd88,
    20'hd9d88, 20'hdfc09, 20'hddc09, 20'hd8d05, 20'hd9c87, 20'hdbe0a, 20'hdbe1a, 20'hdbe4a, 20'hddd88};

  always #5 clk_i = ~clk_i;

  fcd_top i_fcd_top (.clk_i(clk_i), .reset_i(reset_i), .issue_valid_i(issue_valid_i), .issue_opcode_i(issue_opcode_i),
    .issue_mem_i(issue_mem_i), .issue_mem_addr_i(issue_mem_addr_i), .serialize_i(serialize_i),
    .issue_ready_o(issue_ready_o), .rc_i(rc_i), .tag_empty_i(tag_empty_i), .op_data_i(op_data_i),
    .load_data_i(load_data_i), .dp_done_i(dp_done_i), .mem_idle_i(mem_idle_i), .st_req_i(st_req_i),
    .st_split_i(st_split_i), .st_fault_hi_i(st_fault_hi_i), .st_ready_o(st_ready_o), .st_lo_we_o(st_lo_we_o),
    .st_hi_we_o(st_hi_we_o), .st_abort_o(st_abort_o), .dec_valid_o(dec_valid_o), .op_o(op_o), .stk_idx_o(stk_idx_o),
    .pop_o(pop_o), .no_underflow_o(no_underflow_o), .free_o(free_o), .rc_o(rc_o),
    .invalid_opcode_fault_o(invalid_opcode_fault_o), .res_valid_o(res_valid_o), .res_o(res_o), .res_one_o(res_one_o),
    .res_one_we_o(res_one_we_o), .exc_invalid_o(exc_invalid_o), .exc_denormal_o(exc_denormal_o),
    .exc_zdiv_o(exc_zdiv_o), .cc_o(cc_o), .last_mem_ptr_o(last_mem_ptr_o));

  fcd_pipe_model i_fcd_pipe_model (.clk_i(clk_i), .reset_i(reset_i), .dec_valid_i(dec_valid_o), .op_i(op_o),
    .st_lo_we_i(st_lo_we_o), .lat_i(lat), .dp_done_o(dp_done_i), .mem_idle_o(mem_idle_i));

  task automatic check(input logic [95:0] seen, input logic [95:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, expv);
    end
  endtask

  // Entry: {check res, res, fault, res_valid, op, idx, pop, no_underflow, free, zdiv, invalid, denormal}
  task automatic issue(input [15:0] opc, input mem, input [79:0] ld, input [79:0] opd, input [14:0] ctl,
    input chk, input [79:0] res);
    integer n;
    n = 0;
    issue_valid_i = 1;
    issue_opcode_i = opc;
    issue_mem_i = mem;
    issue_mem_addr_i = $random(seed);
    if (mem) last_addr = issue_mem_addr_i;
    load_data_i = ld;
    op_data_i = opd;
    #1;
    while (issue_ready_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
      #1;
    end
    exp_q.push_back({chk, res, ctl});
    @(negedge clk_i);
  endtask

  task automatic store(input s, input f);
    st_req_i = 1;
    st_split_i = s;
    st_fault_hi_i = f;
    @(negedge clk_i);
    st_req_i = 0;
    check(st_lo_we_o, 1'b1);
    @(negedge clk_i);
    check({st_hi_we_o, st_abort_o}, {s & !f, s & f});
    // A split store is still in its high half here, so let it return to idle
    @(negedge clk_i);
  endtask

  task automatic conclude;
    $display("checks=%0d errors=%0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Each decode or fault pulse retires the oldest expectation
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      conclude;
    end else if (!reset_i && (dec_valid_o || invalid_opcode_fault_o)) begin
      if (exp_q.size() == 0) begin
        check(96'h1, 96'h0);
      end else begin
        e = exp_q.pop_front();
        if (invalid_opcode_fault_o)
          check(15'h4000, e[14:0]);
        else
          check({1'b0, res_valid_o, op_o, stk_idx_o, pop_o, no_underflow_o, free_o, exc_zdiv_o, exc_invalid_o,
            exc_denormal_o},
            e[14:0]);
        if (e[95])
          check(res_o, e[94:15]);
      end
    end
  end

  initial begin
    repeat (20) @(negedge clk_i);
    reset_i = 0;
    for (i = 0; i < 32; i++) begin
      t = tbl[i % 16];
      // Legacy opcodes are single codes, so their low bits must stay as listed
      e[2:0] = (t[19:12] == 8'hdb) ? t[6:4] : 3'($random(seed));
      lat = (i % 2) ? 4'h6 : 4'h1;
      issue({t[19:7], e[2:0]}, 0, 0, {$random(seed), $random(seed), 16'($random(seed))},
        {2'b00, t[3:0], e[2:0], (t[3:0] inside {4'h6, 4'h8, 4'h9} && t[19:4] != 16'hddc0),
        t[19:4] == 16'hd9d8, t[3:0] == 4'h9, 3'h0}, 0, 0);
    end
    issue(16'h1234, 0, 0, 0, 15'h4000, 0, 0);
    // Loads: single denormal, double denormal, single signaling NaN, extended denormal
    issue(16'hd900, 1, 80'h1, 0, {2'b01, 4'h1, 3'h0, 6'h01}, 1, 80'h3f6a8000000000000000);
    issue(16'hdd00, 1, 80'h1, 0, {2'b01, 4'h1, 3'h0, 6'h01}, 1, 80'h3bcd8000000000000000);
    issue(16'hd900, 1, 80'h7fa00000, 0, {2'b01, 4'h1, 3'h0, 6'h02}, 1, 80'h7fffe000000000000000);
    issue(16'hdb28, 1, 80'h1, 0, {2'b01, 4'h1, 3'h0, 6'h00}, 1, 80'h1);
    issue(`FCD_OPC_EXTRACT, 0, 0, 80'h0, {2'b01, 4'h2, 3'h4, 6'h04}, 0, 0);
    issue(`FCD_OPC_EXTRACT, 0, 0, 80'h7fff8000000000000000, {2'b01, 4'h2, 3'h4, 6'h00}, 0, 0);
    tag_empty_i = 1;
    issue(`FCD_OPC_EXAM, 0, 0, 0, {2'b01, 4'h4, 3'h5, 6'h00}, 0, 0);
    for (i = 0; i < 4; i++) begin
      rc_i = i[1:0];
      issue(`FCD_OPC_LDPI, 0, 0, 0, {2'b01, 4'h3, 3'h3, 6'h00}, 1,
        {16'h4000, 64'hc90fdaa22168c234 + ((i == 0 || i == 2) ? 64'h1 : 64'h0)});
    end
    issue_valid_i = 0;
    store(1, 0);
    store(1, 1);
    store(0, 0);
    serialize_i = 1;
    issue(`FCD_OPC_LDPI, 0, 0, 0, {2'b01, 4'h3, 3'h3, 6'h00}, 0, 0);
    issue_valid_i = 0;
    serialize_i = 0;
    repeat (20) @(negedge clk_i);
    check(exp_q.size(), 0);
    check(last_mem_ptr_o, last_addr);
    check(rc_o, rc_i);
    conclude;
  end
endmodule
